// File: hdl/dvpip_top.sv
// dual video path with raster timing, pip position control and output mux
`timescale 1ns/100ps
`include "dvpip_defs.svh"
// What this block does
// - stream decoder pulls 4:2:2 samples from 656 stream, flags valid interval
// - interlaced fields are buffered and woven by a field select
// - raster timing issues pixel fetch requests and odd/even field select
// - chroma upsampler gives every pixel its own Cb and Cr pair
// - colour-space stage turns luma/chroma pixels into red, green, blue
// - raster timing makes standard VGA horizontal and vertical sync
// - after start, sequencer writes preset register list to each decoder over I2C
// - lock detector flags unstable decoder output; unstable data is not used
// - pushbutton returns the whole video circuit to its initial state
// - two independent copies of the video path, one per decoder
// - sub-window path fetches pixels at twice the main path rate
// - position controller starts the sub picture at a chosen screen position
// - output mux merges both streams into the one monitor output
// - two switches choose single input 2, single input 1, or pip
module dvpip_top
  import dvpip_pkg::*;
#(
  parameter int unsigned LOCK_TMO_CYC = `LOCK_TMO_NS * `CLK_MHZ / 1000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic circuit_reset_button_n,
  input wire logic display_mode_switch,
  input wire logic source_swap_switch,
  input wire dvpip_dec_pins_t [1:0] dec_pins,
  input wire logic i2c_sda_i,
  output logic i2c_scl_oe,
  output logic i2c_sda_oe,
  output logic raster_hsync,
  output logic raster_vsync,
  output logic vga_blank_n,
  output logic vga_pix_stb,
  output dvpip_rgb_t vga_rgb,
  output logic [1:0] dec_locked,
  output logic cfg_done,
  output logic cfg_nack
);
  logic [1:0] btn_s_q, disp_s_q, swap_s_q;
  logic rst_all_q;
  logic [3:0] pdiv_q, pdiv_d, sdiv_q, sdiv_d;
  logic pix_en, sub_en;
  logic [9:0] h_q, h_d, v_q, v_d, sx_q, sx_d;
  logic vis, in_sub, main_sel;
  dvpip_sync_t now_s;
  dvpip_sync_t [1:0] pipe_q, pipe_d;
  dvpip_rd_req_t main_req, sub_req;
  dvpip_rd_req_t [1:0] req;
  dvpip_ycc_t [1:0] rdat, st_word;
  logic [1:0] st_tick, st_lsb;
  dvpip_rgb_t [1:0] st_rgb;
  logic hs_q, hs_d, vs_q, vs_d, blank_n_q, blank_n_d, stb_q, stb_d;
  dvpip_rgb_t rgb_q, rgb_d;

  function automatic logic [7:0] clip(input logic signed [19:0] x);
    if (x > `PIX_MAX) return 8'hff;
    if (x < 20'sd0) return 8'h00;
    return x[7:0];
  endfunction : clip

  function automatic dvpip_rgb_t ycc_to_rgb(
    input logic [7:0] y,
    input logic [7:0] cb,
    input logic [7:0] cr
  );
    logic signed [19:0] yy, u, v;
    dvpip_rgb_t o;
    yy = signed'({12'h000, y});
    u = signed'({12'h000, cb}) - `C_OFS;
    v = signed'({12'h000, cr}) - `C_OFS;
    o.r = clip(yy + ((`CSC_RV * v) >>> `CSC_SH));
    o.g = clip(yy - ((`CSC_GU * u + `CSC_GV * v) >>> `CSC_SH));
    o.b = clip(yy + ((`CSC_BU * u) >>> `CSC_SH));
    return o;
  endfunction : ycc_to_rgb

  // pins and the button are asynchronous to sys_clk
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      btn_s_q <= '0;
      disp_s_q <= '0;
      swap_s_q <= '0;
      rst_all_q <= 1'b1;
    end else begin
      btn_s_q <= {btn_s_q[0], circuit_reset_button_n};
      disp_s_q <= {disp_s_q[0], display_mode_switch};
      swap_s_q <= {swap_s_q[0], source_swap_switch};
      rst_all_q <= (btn_s_q[1] == `BTN_ON);
    end
  end

  // two paths, one per decoder; each holds its own lock and field lines
  for (genvar p = 0; p < 2; p++) begin : g_path
    dvpip_video_path #(
      .LOCK_TMO_CYC(LOCK_TMO_CYC)
    ) u_path (
      .sys_clk(sys_clk),
      .rst(rst_all_q),
      .pins(dec_pins[p]),
      .rd(req[p]),
      .rd_data(rdat[p]),
      .locked(dec_locked[p]),
      .active()
    );
  end

  dvpip_config_seq u_cfg (
    .sys_clk(sys_clk),
    .rst(rst_all_q),
    .sda_i(i2c_sda_i),
    .scl_oe(i2c_scl_oe),
    .sda_oe(i2c_sda_oe),
    .done(cfg_done),
    .nack(cfg_nack)
  );

  assign pix_en = (pdiv_q == `PIX_DIV);
  assign sub_en = (sdiv_q == `SUB_DIV);

  always_comb begin
    pdiv_d = pix_en ? '0 : pdiv_q + 4'd1;
    sdiv_d = sub_en ? '0 : sdiv_q + 4'd1;
    h_d = h_q;
    v_d = v_q;
    sx_d = sx_q;
    if (pix_en) begin
      h_d = (h_q == `H_END) ? '0 : h_q + 10'd1;
      if (h_q == `H_END) v_d = (v_q == `V_END) ? '0 : v_q + 10'd1;
      if (h_q == `H_END) sx_d = '0;
    end
    vis = (h_q < `H_VIS) && (v_q < `V_VIS);
    in_sub = disp_s_q[1] && (h_q >= `PIP_X0) && (h_q < `PIP_X1)
      && (v_q >= `PIP_Y0) && (v_q < `PIP_Y1);
    if (sub_en && in_sub) sx_d = sx_q + 10'd1;
    // switch on puts input 1 (path 0) in the main window
    main_sel = !swap_s_q[1];
    main_req = '{en: pix_en && vis, field: v_q[0], addr: h_q};
    sub_req = '{en: sub_en && in_sub, field: v_q[0], addr: sx_q};
    req[0] = main_sel ? sub_req : main_req;
    req[1] = main_sel ? main_req : sub_req;
    st_word[0] = rdat[main_sel];
    st_word[1] = rdat[!main_sel];
    st_tick = {sub_en, pix_en};
    st_lsb = {sub_req.addr[0], main_req.addr[0]};
  end

  always_ff @(posedge sys_clk or posedge rst_all_q) begin
    if (rst_all_q) begin
      pdiv_q <= '0;
      sdiv_q <= '0;
      h_q <= '0;
      v_q <= '0;
      sx_q <= '0;
    end else begin
      pdiv_q <= pdiv_d;
      sdiv_q <= sdiv_d;
      h_q <= h_d;
      v_q <= v_d;
      sx_q <= sx_d;
    end
  end

  // per stream: even words carry Cb, odd words Cr; reuse the last pair
  for (genvar s = 0; s < 2; s++) begin : g_up
    logic lsb_q, lsb_d;
    logic [7:0] y_q, y_d, cb_q, cb_d, cr_q, cr_d;
    always_comb begin
      lsb_d = lsb_q;
      y_d = y_q;
      cb_d = cb_q;
      cr_d = cr_q;
      if (st_tick[s]) begin
        lsb_d = st_lsb[s];
        y_d = st_word[s].y;
        if (lsb_q) cr_d = st_word[s].c;
        else cb_d = st_word[s].c;
      end
    end
    always_ff @(posedge sys_clk or posedge rst_all_q) begin
      if (rst_all_q) begin
        lsb_q <= 1'b0;
        y_q <= '0;
        cb_q <= `C_MID;
        cr_q <= `C_MID;
      end else begin
        lsb_q <= lsb_d;
        y_q <= y_d;
        cb_q <= cb_d;
        cr_q <= cr_d;
      end
    end
    assign st_rgb[s] = ycc_to_rgb(y_q, cb_q, cr_q);
  end

  // timing is delayed two pixels to meet the fetch and upsample stages
  always_comb begin
    now_s = '{hs: (h_q >= `H_SS) && (h_q < `H_SE),
              vs: (v_q >= `V_SS) && (v_q < `V_SE),
              vis: vis,
              sub: in_sub};
    pipe_d = pipe_q;
    hs_d = hs_q;
    vs_d = vs_q;
    blank_n_d = blank_n_q;
    rgb_d = rgb_q;
    stb_d = pix_en;
    if (pix_en) begin
      pipe_d = {pipe_q[0], now_s};
      hs_d = pipe_q[1].hs ? `SYNC_ON : !`SYNC_ON;
      vs_d = pipe_q[1].vs ? `SYNC_ON : !`SYNC_ON;
      blank_n_d = pipe_q[1].vis;
      if (!pipe_q[1].vis) rgb_d = '0;
      else if (pipe_q[1].sub) rgb_d = st_rgb[1];
      else rgb_d = st_rgb[0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst_all_q) begin
    if (rst_all_q) begin
      pipe_q <= '0;
      hs_q <= !`SYNC_ON;
      vs_q <= !`SYNC_ON;
      blank_n_q <= 1'b0;
      stb_q <= 1'b0;
      rgb_q <= '0;
    end else begin
      pipe_q <= pipe_d;
      hs_q <= hs_d;
      vs_q <= vs_d;
      blank_n_q <= blank_n_d;
      stb_q <= stb_d;
      rgb_q <= rgb_d;
    end
  end

  assign raster_hsync = hs_q;
  assign raster_vsync = vs_q;
  assign vga_blank_n = blank_n_q;
  assign vga_pix_stb = stb_q;
  assign vga_rgb = rgb_q;

  line_wrap_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    pix_en && (h_q == `H_END) |=> (h_q == 10'd0)) else $error("line did not wrap");
  hsync_width_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    $fell(raster_hsync) |-> !raster_hsync [*8]) else $error("hsync pulse too short");
  pix_rate_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    pix_en |=> !pix_en [*8] ##1 !pix_en ##1 pix_en) else $error("main pixel period wrong");
  sub_rate_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    sub_en |=> !sub_en [*4] ##1 sub_en) else $error("sub pixel period wrong");
  fetch_area_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    main_req.en |-> vis && (main_req.field == v_q[0])) else $error("fetch outside picture");
  sub_pos_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    sub_req.en |-> (h_q >= `PIP_X0) && (v_q >= `PIP_Y0)) else $error("sub fetch misplaced");
  single_mode_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    !disp_s_q[1] |-> !sub_req.en) else $error("sub window in single mode");
  route_sel_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    main_req.en |-> (swap_s_q[1] ? req[0].en : req[1].en)) else $error("main routed wrong");
  mux_sub_a: assert property (@(posedge sys_clk) disable iff (rst_all_q)
    pix_en && pipe_q[1].vis && pipe_q[1].sub |=> (vga_rgb == $past(st_rgb[1])))
    else $error("sub pixel not passed");
  button_rst_a: assert property (@(posedge sys_clk) disable iff (rst)
    (btn_s_q[1] == `BTN_ON) |=> rst_all_q) else $error("button did not reset");
endmodule : dvpip_top

// File: inc/dvpip_defs.svh
// named constants of the dual video pip display path
`ifndef DVPIP_DEFS_SVH
`define DVPIP_DEFS_SVH
`define CLK_MHZ 250
`define PIX_DIV 4'd9
`define SUB_DIV 4'd4
`define H_VIS 10'd640
`define H_SS 10'd656
`define H_SE 10'd752
`define H_END 10'd799
`define V_VIS 10'd480
`define V_SS 10'd490
`define V_SE 10'd492
`define V_END 10'd524
`define PIP_X0 10'd288
`define PIP_X1 10'd608
`define PIP_Y0 10'd208
`define PIP_Y1 10'd448
`define SYNC_ON 1'b0
`define BTN_ON 1'b0
`define LINE_WORDS 720
`define IDX_END 10'd720
`define TRS_FF 8'hff
`define TRS_00 8'h00
`define XY_F 6
`define XY_V 5
`define XY_H 4
`define LOCK_LINES 8'd200
`define LOCK_TMO_NS 100000
`define C_MID 8'h80
`define C_OFS 20'sd128
`define PIX_MAX 20'sd255
`define CSC_SH 8
`define CSC_RV 20'sd359
`define CSC_GU 20'sd88
`define CSC_GV 20'sd183
`define CSC_BU 20'sd454
`define I2C_KHZ 100
`define I2C_QTR_CYC (`CLK_MHZ * 1000 / (4 * `I2C_KHZ))
`define FRAME_BITS 5'd27
`define FRAME_MSB 26
`define BYTE_SLOTS 5'd9
`define ACK_SLOT 5'd8
`define PH_SET 2'd0
`define PH_RISE 2'd1
`define PH_SAMP 2'd2
`define PH_FALL 2'd3
`define CFG_LAST 2'd3
`define DEC0_ADDR 8'h40
`define DEC1_ADDR 8'h42
`define CFG_E0 16'h0000
`define CFG_E1 16'h0304
`define CFG_E2 16'h1741
`define CFG_E3 16'h3a16
`endif

// File: inc/dvpip_pkg.sv
// types shared by the dual video pip display path
package dvpip_pkg;
  typedef struct packed {logic [7:0] y; logic [7:0] c;} dvpip_ycc_t;
  typedef struct packed {logic [7:0] r; logic [7:0] g; logic [7:0] b;} dvpip_rgb_t;
  typedef struct packed {logic clk; logic [7:0] data;} dvpip_dec_pins_t;
  typedef struct packed {logic en; logic field; logic [9:0] addr;} dvpip_rd_req_t;
  typedef struct packed {logic hs; logic vs; logic vis; logic sub;} dvpip_sync_t;
  typedef enum logic [3:0] {
    CFG_START = 4'b0001,
    CFG_BIT = 4'b0010,
    CFG_STOP = 4'b0100,
    CFG_DONE = 4'b1000
  } dvpip_cfg_st_t;
endpackage : dvpip_pkg

// File: hdl/dvpip_video_path.sv
// stream decoder, lock detector and field buffer of one video input
`timescale 1ns/100ps
`include "dvpip_defs.svh"
module dvpip_video_path
  import dvpip_pkg::*;
#(
  parameter int unsigned LOCK_TMO_CYC = 25000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire dvpip_dec_pins_t pins,
  input wire dvpip_rd_req_t rd,
  output dvpip_ycc_t rd_data,
  output logic locked,
  output logic active
);
  dvpip_dec_pins_t s1_q, s2_q, s3_q;
  logic [23:0] hist_q, hist_d, tmo_q, tmo_d;
  logic act_q, act_d, fld_q, fld_d, ph_q, ph_d, lk_q, lk_d;
  logic [7:0] c_q, c_d, good_q, good_d;
  logic [9:0] idx_q, idx_d;
  logic strobe, is_xy, wr_en;
  logic [15:0] mem [2][`LINE_WORDS];
  dvpip_ycc_t rd_q;

  assign strobe = s2_q.clk && !s3_q.clk;
  assign is_xy = strobe && (hist_q == {`TRS_FF, `TRS_00, `TRS_00});

  always_comb begin
    hist_d = hist_q;
    act_d = act_q;
    fld_d = fld_q;
    ph_d = ph_q;
    c_d = c_q;
    idx_d = idx_q;
    good_d = good_q;
    tmo_d = tmo_q + 24'd1;
    wr_en = 1'b0;
    if (tmo_q == 24'(LOCK_TMO_CYC - 1)) begin
      tmo_d = tmo_q;
      good_d = '0;
    end
    if (strobe) hist_d = {hist_q[15:0], s2_q.data};
    if (is_xy) begin
      tmo_d = '0;
      fld_d = s2_q.data[`XY_F];
      act_d = !s2_q.data[`XY_V] && !s2_q.data[`XY_H];
      idx_d = '0;
      ph_d = 1'b0;
      if (s2_q.data[`XY_H] && good_q != `LOCK_LINES) good_d = good_q + 8'd1;
    end else if (strobe && act_q) begin
      ph_d = !ph_q;
      if (!ph_q) begin
        c_d = s2_q.data;
      end else begin
        idx_d = idx_q + 10'd1;
        wr_en = lk_q && (idx_q < `IDX_END);
      end
    end
    lk_d = (good_d == `LOCK_LINES);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      hist_q <= '0;
      tmo_q <= '0;
      act_q <= 1'b0;
      fld_q <= 1'b0;
      ph_q <= 1'b0;
      lk_q <= 1'b0;
      c_q <= '0;
      good_q <= '0;
      idx_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      hist_q <= hist_d;
      tmo_q <= tmo_d;
      act_q <= act_d;
      fld_q <= fld_d;
      ph_q <= ph_d;
      lk_q <= lk_d;
      c_q <= c_d;
      good_q <= good_d;
      idx_q <= idx_d;
    end
  end

  // one line per field; the raster picks the field to weave
  always_ff @(posedge sys_clk) begin
    if (wr_en) mem[fld_q][idx_q] <= {s2_q.data, c_q};
    if (rd.en) rd_q <= mem[rd.field][rd.addr];
  end

  assign rd_data = rd_q;
  assign locked = lk_q;
  assign active = act_q;

  lock_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en |-> lk_q && act_q && ph_q) else $error("sample written while unlocked");
  lock_loss_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tmo_q == 24'(LOCK_TMO_CYC - 1)) && !strobe |=> !lk_q) else $error("lock kept after timeout");
endmodule : dvpip_video_path

// File: hdl/dvpip_config_seq.sv
// decoder_config_sequencer: writes the preset list into both decoders
`timescale 1ns/100ps
`include "dvpip_defs.svh"
module dvpip_config_seq
  import dvpip_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe,
  output logic done,
  output logic nack
);
  dvpip_cfg_st_t st_q, st_d;
  logic [1:0] sda_s_q, ph_q, ph_d, ent_q, ent_d;
  logic [9:0] qtr_q, qtr_d;
  logic [4:0] bit_q, bit_d;
  logic [26:0] sh_q, sh_d;
  logic dev_q, dev_d, scl_q, scl_d, sda_q, sda_d, done_q, done_d, nack_q, nack_d, tick;
  logic [15:0] w;

  function automatic logic [15:0] cfg_word(input logic [1:0] i);
    unique case (i)
      2'd0: return `CFG_E0;
      2'd1: return `CFG_E1;
      2'd2: return `CFG_E2;
      2'd3: return `CFG_E3;
    endcase
  endfunction : cfg_word

  assign tick = (qtr_q == 10'(`I2C_QTR_CYC - 1));
  assign w = cfg_word(ent_q);

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    ent_d = ent_q;
    dev_d = dev_q;
    bit_d = bit_q;
    sh_d = sh_q;
    scl_d = scl_q;
    sda_d = sda_q;
    done_d = done_q;
    nack_d = nack_q;
    qtr_d = tick ? '0 : qtr_q + 10'd1;
    if (tick) begin
      ph_d = ph_q + 2'd1;
      unique case (st_q)
        CFG_START: begin
          if (ph_q == `PH_SET) sda_d = 1'b1;
          if (ph_q == `PH_RISE) scl_d = 1'b1;
          if (ph_q == `PH_FALL) begin
            st_d = CFG_BIT;
            bit_d = '0;
            sh_d = {dev_q ? `DEC1_ADDR : `DEC0_ADDR, 1'b1, w[15:8], 1'b1, w[7:0], 1'b1};
          end
        end
        CFG_BIT: begin
          if (ph_q == `PH_SET) sda_d = !sh_q[`FRAME_MSB];
          if (ph_q == `PH_RISE) scl_d = 1'b0;
          if (ph_q == `PH_SAMP && (bit_q % `BYTE_SLOTS) == `ACK_SLOT && sda_s_q[1]) nack_d = 1'b1;
          if (ph_q == `PH_FALL) begin
            scl_d = 1'b1;
            sh_d = {sh_q[25:0], 1'b1};
            bit_d = bit_q + 5'd1;
            if (bit_q == `FRAME_BITS - 5'd1) st_d = CFG_STOP;
          end
        end
        CFG_STOP: begin
          if (ph_q == `PH_SET) sda_d = 1'b1;
          if (ph_q == `PH_RISE) scl_d = 1'b0;
          if (ph_q == `PH_SAMP) sda_d = 1'b0;
          if (ph_q == `PH_FALL) begin
            st_d = CFG_START;
            ent_d = ent_q + 2'd1;
            if (ent_q == `CFG_LAST) dev_d = 1'b1;
            if (ent_q == `CFG_LAST && dev_q) begin
              st_d = CFG_DONE;
              done_d = 1'b1;
            end
          end
        end
        CFG_DONE: ph_d = ph_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= CFG_START;
      sda_s_q <= 2'b11;
      ph_q <= '0;
      ent_q <= '0;
      qtr_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      dev_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sda_s_q <= {sda_s_q[0], sda_i};
      ph_q <= ph_d;
      ent_q <= ent_d;
      qtr_q <= qtr_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      dev_q <= dev_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      done_q <= done_d;
      nack_q <= nack_d;
    end
  end

  assign scl_oe = scl_q;
  assign sda_oe = sda_q;
  assign done = done_q;
  assign nack = nack_q;

  cfg_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    done_q |=> done_q && !scl_q && !sda_q) else $error("bus not released after list");
  sda_move_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == CFG_BIT) && $changed(sda_q) |-> scl_q) else $error("data moved with clock high");
endmodule : dvpip_config_seq

// File: testbench/dvpip_partner.sv
// behavioural decoder chips and i2c target facing the pip display path
`timescale 1ns/100ps
module dvpip_partner
  import dvpip_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic ack_oe,
  output dvpip_dec_pins_t [1:0] pins,
  output int lines
);
  localparam logic [7:0] YV [2] = '{8'h50, 8'ha0};
  localparam logic [7:0] CB [2] = '{8'h90, 8'h80};
  localparam logic [7:0] CR [2] = '{8'h80, 8'h90};
  logic [2:0] div;
  int pos;
  int words;
  logic scl_q, sda_q;
  int bitn;
  // short lines until lock, then full lines so both field buffers fill
  assign words = (lines < 202) ? 8 : 720;
  function automatic logic [7:0] stream_byte(input int i, input int p, input logic f);
    int k;
    k = p - 8;
    if (p == 0 || p == 4) return 8'hff;
    if (p < 3 || p == 5 || p == 6) return 8'h00;
    if (p == 3) return {1'b1, f, 1'b0, 1'b1, 4'h0};
    if (p == 7) return {1'b1, f, 1'b0, 1'b0, 4'h0};
    if (k[0]) return YV[i];
    return k[1] ? CR[i] : CB[i];
  endfunction : stream_byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
      pos <= 0;
      lines <= 0;
    end else if (!hold) begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
        pos <= (pos == 7 + 2 * words) ? 0 : pos + 1;
        if (pos == 7 + 2 * words) lines <= lines + 1;
      end
    end
  end
  // byte changes four clocks before the byte clock rises; stalled stream shows junk
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pins[i].clk = !hold && div[2];
      pins[i].data = hold ? ~stream_byte(i, pos, lines[0]) : stream_byte(i, pos, lines[0]);
    end
  end
  // i2c target: acknowledges the ninth bit of every byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitn <= 0;
      ack_oe <= 1'b0;
    end else begin
      scl_q <= !scl_oe;
      sda_q <= !sda_oe;
      if (!scl_oe && scl_q && sda_q && sda_oe) bitn <= 0;
      else if (!scl_oe && !scl_q) bitn <= bitn + 1;
      if (scl_oe && scl_q) ack_oe <= (bitn == 8 || bitn == 17 || bitn == 26);
    end
  end
endmodule : dvpip_partner

// File: testbench/test_dvpip_top.sv
// self-checking bench for the dual video pip display path
`timescale 1ns/100ps
module test_dvpip_top;
  import dvpip_pkg::*;
  logic sys_clk, rst, btn_n, mode_sw, swap_sw, hold, ack_oe, sda_wire;
  dvpip_dec_pins_t [1:0] dec_pins;
  logic scl_oe, sda_oe, hs, vs, blank_n, stb, done, nack;
  dvpip_rgb_t rgb;
  logic [1:0] locked;
  int lines, errors, comparisons;
  assign sda_wire = !(sda_oe || ack_oe);
  dvpip_top #(.LOCK_TMO_CYC(12000)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .circuit_reset_button_n(btn_n), .display_mode_switch(mode_sw),
    .source_swap_switch(swap_sw), .dec_pins(dec_pins), .i2c_sda_i(sda_wire),
    .i2c_scl_oe(scl_oe), .i2c_sda_oe(sda_oe), .raster_hsync(hs), .raster_vsync(vs),
    .vga_blank_n(blank_n), .vga_pix_stb(stb), .vga_rgb(rgb), .dec_locked(locked),
    .cfg_done(done), .cfg_nack(nack));
  dvpip_partner i_partner (.sys_clk(sys_clk), .rst(rst), .hold(hold), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .ack_oe(ack_oe), .pins(dec_pins), .lines(lines));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_up();
    errors++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask : give_up
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) give_up();
    end
  endtask : wait_lvl
  task automatic wait_lines(input int target);
    int n;
    n = 0;
    while (lines < target) begin
      @(negedge sys_clk);
      n++;
      if (n > 80000) give_up();
    end
  endtask : wait_lines
  // start condition then the first device address, msb first
  task automatic i2c_first_byte();
    logic [7:0] a;
    a = 8'h00;
    wait_lvl(sda_oe, 1'b1, 3000);
    check(scl_oe, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wait_lvl(scl_oe, 1'b1, 3000);
      wait_lvl(scl_oe, 1'b0, 3000);
      a = {a[6:0], sda_wire};
    end
    check(a, 8'h40);
  endtask : i2c_first_byte
  task automatic lock_check();
    int n;
    n = 0;
    wait_lines(150);
    check(locked, 2'b00);
    wait_lines(201);
    while (locked !== 2'b11 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    check(locked, 2'b11);
  endtask : lock_check
  // one full line from hsync rise to the next rise
  task automatic raster_line();
    int cyc, nstb, nlow, nvis, last, gap_bad, blank_nz, t_b, t_f;
    logic low_seen, blank_q;
    {cyc, nstb, nlow, nvis, last, gap_bad, blank_nz, t_b, t_f} = '0;
    low_seen = 1'b0;
    blank_q = 1'b0;
    wait_lvl(hs, 1'b0, 9000);
    wait_lvl(hs, 1'b1, 2000);
    while (!(low_seen && hs === 1'b1) && cyc < 9000) begin
      @(negedge sys_clk);
      cyc++;
      if (blank_q && blank_n === 1'b0) t_b = cyc;
      if (!low_seen && hs === 1'b0) t_f = cyc;
      blank_q = blank_n;
      if (hs === 1'b0) low_seen = 1'b1;
      if (stb === 1'b1) begin
        nstb++;
        if (hs === 1'b0) nlow++;
        if (blank_n === 1'b1) nvis++;
        if (blank_n === 1'b0 && rgb !== '0) blank_nz++;
        if (last != 0 && cyc - last != 10) gap_bad++;
        last = cyc;
      end
    end
    check(cyc, 8000);
    check(nstb, 800);
    check(nlow, 96);
    check(nvis, 640);
    check(t_f - t_b, 160);
    check(gap_bad, 0);
    check(blank_nz, 0);
    check(vs, 1'b1);
  endtask : raster_line
  // all four switch settings within one visible line, top rows outside sub window
  task automatic display_modes();
    logic [1:0] m;
    logic [15:0] exp_rb;
    wait_lvl(blank_n, 1'b0, 9000);
    wait_lvl(blank_n, 1'b1, 9000);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      mode_sw = m[1];
      swap_sw = m[0];
      exp_rb = m[0] ? 16'h506c : 16'hb6a0;
      repeat (600) @(negedge sys_clk);
      check(rgb.r, exp_rb[15:8]);
      check(rgb.b, exp_rb[7:0]);
    end
    check(nack, 1'b0);
    mode_sw = 1'b0;
    swap_sw = 1'b1;
  endtask : display_modes
  task automatic lock_loss();
    int n;
    n = 0;
    hold = 1'b1;
    while (locked !== 2'b00 && n < 13000) begin
      @(negedge sys_clk);
      n++;
    end
    check(locked, 2'b00);
  endtask : lock_loss
  task automatic button_reset();
    btn_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    check({hs, vs, blank_n, stb, rgb}, {4'b1100, 24'h0});
    check({scl_oe, sda_oe, locked, done}, 5'h00);
    btn_n = 1'b1;
  endtask : button_reset
  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    btn_n = 1'b1;
    mode_sw = 1'b0;
    swap_sw = 1'b1;
    hold = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    i2c_first_byte();
    lock_check();
    wait_lines(204);
    raster_line();
    display_modes();
    lock_loss();
    button_reset();
    tally_and_finish();
  end
endmodule : test_dvpip_top
